// file: core/ctu_pkg.sv
// Package of register map, field layout and encodings for the edge timing block
package ctu_pkg;
    // Register byte offsets
    localparam logic [11:0] EDGE_CONTROL_OFF = 12'h000;
    localparam logic [11:0] CURRENT_CONTROL_OFF = 12'h004;
    localparam logic [11:0] IRQ_STATUS_OFF = 12'h008;
    localparam logic [11:0] IRQ_CLEAR_OFF = 12'h00c;
    localparam logic [11:0] IRQ_ENABLE_OFF = 12'h010;
    // Edge control field positions
    localparam int ENABLE_BIT = 15;
    localparam int TIME_GEN_BIT = 12;
    localparam int EDGE_EN_BIT = 11;
    localparam int ORDER_EN_BIT = 10;
    localparam int SECOND_POL_BIT = 7;
    localparam int SECOND_SRC_LSB = 5;
    localparam int FIRST_POL_BIT = 4;
    localparam int FIRST_SRC_LSB = 2;
    localparam int SECOND_FLAG_BIT = 1;
    localparam int FIRST_FLAG_BIT = 0;
    // Current control field positions
    localparam int TRIM_LSB = 10;
    localparam int RANGE_LSB = 8;
    // Writable bits of edge control (bits 14 and status bits excluded)
    localparam logic [15:0] EDGE_CONTROL_WMASK = 16'hbffc;
    localparam logic [15:0] EDGE_CONTROL_RESET = 16'h0000;
    localparam logic [15:0] CURRENT_CONTROL_WMASK = 16'hff00;
    localparam logic [15:0] CURRENT_CONTROL_RESET = 16'h0000;
    // Source selector encoding
    typedef enum logic [1:0] {
        CTU_SRC_TIMER = 2'h0,
        CTU_SRC_COMPARE = 2'h1,
        CTU_SRC_PIN_B = 2'h2,
        CTU_SRC_PIN_A = 2'h3
    } ctu_src_t;
endpackage

// file: core/ctu_edge_detect.sv
// Per-channel source selection and polarity edge detector
`timescale 1ns/1ps
module ctu_edge_detect (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] sel,
    input wire logic pol,
    input wire logic [3:0] sources,
    output logic event_pulse
);
    typedef struct packed {
        logic prev;
        logic primed;
    } ctu_det_state_t;

    ctu_det_state_t st_r;
    ctu_det_state_t st_nxt;
    logic cur;

    always_comb begin
        // Sources are ordered so the selector indexes them directly
        cur = sources[sel]; // [R1]
        st_nxt.prev = cur;
        st_nxt.primed = 1'b1;
        // Polarity high: rising edge counts; low: falling edge
        if (pol) begin // [R6]
            event_pulse = st_r.primed & cur & ~st_r.prev;
        end else begin
            event_pulse = st_r.primed & ~cur & st_r.prev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

// file: core/ctu_edge_timing.sv
// Edge timing control: APB registers, edge channels, flags and interrupt
// Notes on behaviour
// [R1] Two-bit selector: pin A, pin B, compare, timer
// [R2] Second-edge event sets flag bit one
// [R3] First-edge event sets flag bit zero
// [R4] Software routes pins before enabling time generation
// [R5] Trim and range in high byte, low zero
// [R6] Polarity bit picks rising or falling edge
// [R7] Ordered mode: second edge needs first flag
// [R8] Trim field is a signed current adjustment
// [R9] Range field selects base current multiple
`timescale 1ns/1ps
module ctu_edge_timing (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic edge_pin_a,
    input wire logic edge_pin_b,
    input wire logic output_compare_unit,
    input wire logic timer_unit,
    output logic unit_enable,
    output logic time_generation_enable,
    output logic signed [5:0] current_trim,
    output logic [1:0] current_range,
    output logic irq
);
    typedef struct packed {
        logic [15:0] edge_control;
        logic [15:0] current_control;
        logic [1:0] irq_status;
        logic [1:0] irq_enable;
        logic [31:0] rdata;
    } ctu_state_t;

    ctu_state_t st_r;
    ctu_state_t st_nxt;
    logic [3:0] sources;
    logic first_ev;
    logic second_ev;
    logic second_ok;
    logic wr;
    logic rd;
    logic hit;
    logic [15:0] wdata16;

    // Index order matches the selector codes
    assign sources = {edge_pin_a, edge_pin_b, output_compare_unit,
        timer_unit}; // [R1]

    ctu_edge_detect u_first (
        .pclk(pclk),
        .presetn(presetn),
        .sel(st_r.edge_control[ctu_pkg::FIRST_SRC_LSB +: 2]),
        .pol(st_r.edge_control[ctu_pkg::FIRST_POL_BIT]),
        .sources(sources),
        .event_pulse(first_ev)
    );

    ctu_edge_detect u_second (
        .pclk(pclk),
        .presetn(presetn),
        .sel(st_r.edge_control[ctu_pkg::SECOND_SRC_LSB +: 2]),
        .pol(st_r.edge_control[ctu_pkg::SECOND_POL_BIT]),
        .sources(sources),
        .event_pulse(second_ev)
    );

    // Zero-wait slave; every access completes in its access phase
    assign pready = 1'b1;
    assign wr = psel & penable & pwrite;
    assign rd = psel & ~penable & ~pwrite;
    assign wdata16 = pwdata[15:0];
    assign hit = (paddr == ctu_pkg::EDGE_CONTROL_OFF)
        | (paddr == ctu_pkg::CURRENT_CONTROL_OFF)
        | (paddr == ctu_pkg::IRQ_STATUS_OFF)
        | (paddr == ctu_pkg::IRQ_CLEAR_OFF)
        | (paddr == ctu_pkg::IRQ_ENABLE_OFF);
    assign pslverr = psel & penable & ~hit;
    assign prdata = st_r.rdata;

    assign unit_enable = st_r.edge_control[ctu_pkg::ENABLE_BIT];
    // Pin routing is software's job before this is set
    assign time_generation_enable =
        st_r.edge_control[ctu_pkg::TIME_GEN_BIT]; // [R4]
    // Two's complement: 6'h1f max up, 6'h20 max down
    assign current_trim =
        st_r.current_control[ctu_pkg::TRIM_LSB +: 6]; // [R8]
    assign current_range =
        st_r.current_control[ctu_pkg::RANGE_LSB +: 2]; // [R9]
    assign irq = |(st_r.irq_status & st_r.irq_enable);

    always_comb begin
        logic edges_on;
        logic set_first;
        logic set_second;
        edges_on = st_r.edge_control[ctu_pkg::ENABLE_BIT]
            & st_r.edge_control[ctu_pkg::EDGE_EN_BIT];
        st_nxt = st_r;
        // Ordered mode blocks a second edge until the first is seen
        second_ok = ~st_r.edge_control[ctu_pkg::ORDER_EN_BIT]
            | st_r.edge_control[ctu_pkg::FIRST_FLAG_BIT]; // [R7]
        set_first = edges_on & first_ev;
        set_second = edges_on & second_ev & second_ok; // [R7]
        if (wr) begin
            case (paddr)
                ctu_pkg::EDGE_CONTROL_OFF: begin
                    // Flags are writable too, so software can clear them
                    st_nxt.edge_control = wdata16
                        & (ctu_pkg::EDGE_CONTROL_WMASK | 16'h0003);
                end
                ctu_pkg::CURRENT_CONTROL_OFF: begin
                    st_nxt.current_control = wdata16
                        & ctu_pkg::CURRENT_CONTROL_WMASK; // [R5]
                end
                ctu_pkg::IRQ_CLEAR_OFF: begin
                    st_nxt.irq_status = st_r.irq_status & ~pwdata[1:0];
                end
                ctu_pkg::IRQ_ENABLE_OFF: begin
                    st_nxt.irq_enable = pwdata[1:0];
                end
                default: begin
                end
            endcase
        end
        // Hardware set wins over a clear in the same cycle
        if (set_first) begin
            st_nxt.edge_control[ctu_pkg::FIRST_FLAG_BIT] = 1'b1; // [R3]
            st_nxt.irq_status[0] = 1'b1;
        end
        if (set_second) begin
            st_nxt.edge_control[ctu_pkg::SECOND_FLAG_BIT] = 1'b1; // [R2]
            st_nxt.irq_status[1] = 1'b1;
        end
        // Read data registered in setup, valid in the access phase
        if (rd) begin
            case (paddr)
                ctu_pkg::EDGE_CONTROL_OFF: begin
                    st_nxt.rdata = {16'h0000, st_r.edge_control};
                end
                ctu_pkg::CURRENT_CONTROL_OFF: begin
                    st_nxt.rdata = {16'h0000,
                        st_r.current_control & 16'hff00}; // [R5]
                end
                ctu_pkg::IRQ_STATUS_OFF: begin
                    st_nxt.rdata = {30'h00000000, st_r.irq_status};
                end
                ctu_pkg::IRQ_ENABLE_OFF: begin
                    st_nxt.rdata = {30'h00000000, st_r.irq_enable};
                end
                default: begin
                    st_nxt.rdata = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r.edge_control <= ctu_pkg::EDGE_CONTROL_RESET;
            st_r.current_control <= ctu_pkg::CURRENT_CONTROL_RESET; // [R5]
            st_r.irq_status <= 2'h0;
            st_r.irq_enable <= 2'h0;
            st_r.rdata <= 32'h00000000;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

// file: tb/ctu_asserts.sv
// Port checker for the edge timing block
`timescale 1ns/1ps
module ctu_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic signed [5:0] current_trim,
    input wire logic [1:0] current_range,
    input wire logic irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic acc, wr, cw;
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign cw = wr && paddr == 12'h004;
    chk_trim_load: assert property (cw |=>
        current_trim == $past(pwdata[15:10])) else $error("trim wrong");
    chk_range_load: assert property (cw |=>
        current_range == $past(pwdata[9:8])) else $error("range wrong");
    chk_ctrl_hold: assert property (!cw |=>
        $stable({current_trim, current_range})) else $error("ctrl moved");
    chk_low_zero: assert property (psel && !penable && !pwrite &&
        paddr == 12'h004 |=> prdata[7:0] == 8'h00) else $error("low byte");
    chk_unmapped_err: assert property (acc && paddr > 12'h010 |-> pslverr)
        else $error("no slverr");
    chk_mapped_ok: assert property (acc && paddr == 12'h004 |-> !pslverr)
        else $error("bad slverr");
    chk_irq_mask: assert property (wr && paddr == 12'h010 &&
        pwdata[1:0] == 2'h0 |=> !irq) else $error("irq not masked");
    chk_irq_sticky: assert property (irq && !wr |=> irq)
        else $error("irq dropped");
    cover property (irq);
    cover property (acc && pslverr);
    cover property (cw);
endmodule

// file: tb/ctu_src_model.sv
// Model of the four event sources feeding the block
`timescale 1ns/1ps
module ctu_src_model (
    input wire logic pclk,
    input wire logic [3:0] lvl,
    output logic [3:0] src
);
    // Sources move just after the clock, as on-chip units do
    always_ff @(posedge pclk) src <= lvl;
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the edge timing block
`timescale 1ns/1ps
module tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
    logic pready, pslverr, irq, ue, tg;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q, d;
    logic [31:0] corner [4] = '{32'h7dff, 32'h00ff, 32'hfe00, 32'h87ff};
    logic [3:0] lvl = 4'h0, src;
    int mismatches = 0, n_compared = 0;
    ctu_src_model src_m (.pclk, .lvl, .src);
    ctu_edge_timing dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .edge_pin_a(src[3]),
        .edge_pin_b(src[2]), .output_compare_unit(src[1]),
        .timer_unit(src[0]), .unit_enable(ue), .time_generation_enable(tg),
        .current_trim(), .current_range(), .irq);
    initial forever #20 pclk = ~pclk;
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One idle cycle after each transfer keeps drives one per time step
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] v);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            mismatches++;
            final_report();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic settle(input logic [3:0] v);
        lvl <= v;
        repeat (3) @(posedge pclk);
    endtask
    function automatic logic [31:0] cfg(int c, int s, int p);
        return c ? 32'h8800 | s << 5 | p << 7 : 32'h8800 | s << 2 | p << 4;
    endfunction
    initial begin
        q = $urandom(88);
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, 12'h000, 0);
        chk(q, 0);
        apb(0, 12'h004, 0);
        chk(q, 0);
        for (int j = 0; j < 12; j++) begin
            d = j < 4 ? corner[j] : $urandom;
            apb(1, 12'h004, d);
            apb(0, 12'h004, 0);
            chk(q, d & 32'hff00);
        end
        $display("test current control done");
        for (int c = 0; c < 2; c++) for (int s = 0; s < 4; s++)
            for (int p = 0; p < 2; p++) begin
                settle(p ? 4'hf : 4'h0);
                apb(1, 12'h000, cfg(c, s, p));
                d = {28'h0, lvl};
                d[s] = !p;
                settle(d[3:0]);
                apb(0, 12'h000, 0);
                chk(q[c], 0);
                d[s] = p;
                settle(d[3:0]);
                apb(0, 12'h000, 0);
                chk(q[c], 1);
            end
        $display("test edge sources done");
        settle(4'h0);
        apb(1, 12'h00c, 3);
        apb(1, 12'h010, 3);
        apb(1, 12'h000, 32'h9cdc);
        chk(ue, 1);
        chk(tg, 1);
        settle(4'h4);
        apb(0, 12'h000, 0);
        chk(q[1:0], 0);
        chk(irq, 0);
        settle(4'h8);
        settle(4'hc);
        apb(0, 12'h000, 0);
        chk(q[1:0], 3);
        apb(0, 12'h008, 0);
        chk(q, 3);
        chk(irq, 1);
        apb(1, 12'h010, 0);
        chk(irq, 0);
        apb(1, 12'h010, 3);
        apb(1, 12'h00c, 3);
        chk(irq, 0);
        apb(1, 12'h020, 32'hffff);
        chk(e, 1);
        apb(0, 12'h020, 0);
        chk(q, 0);
        chk(e, 1);
        $display("test order and irq done");
        final_report();
    end
endmodule
bind ctu_edge_timing ctu_asserts chk_u (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pslverr, .current_trim,
    .current_range, .irq);
